// >>> wlock_pkg.sv
// constants for the write-lock and scratch block of the device command port
// assumes a command/data word port clocked by the controller clock
// Contract
// - suspended state rejects scratch writes and clears the write enable
// - reads always complete, locked or suspended
// - unlock value AA37H re-enables writes after resume
// - command B0 then one data word unlocks
// - scratch written by B2, read by B3
// - scratch holds last write, resets to zero
`default_nettype none
package wlock_pkg;
  // ----------------------------------------------------------------
  // command codes and values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_UNLOCK        = 8'h_B0;    // unlock device
  localparam logic [7:0]  CMD_SCRATCH_WR    = 8'h_B2;    // write scratch
  localparam logic [7:0]  CMD_SCRATCH_RD    = 8'h_B3;    // read scratch
  localparam logic [15:0] UNLOCK_KEY        = 16'h_AA37; // unlock code
  localparam logic [15:0] SCRATCH_RESET     = 16'h_0000; // scratch reset
  localparam logic [15:0] WORD_ZERO         = 16'h_0000; // idle read data
  localparam int          WORD_W            = 16;        // data word width
  // pending data phase after a command
  typedef enum logic [1:0]
  {
    PEND_NONE     = 2'b00,
    PEND_UNLOCK   = 2'b01,
    PEND_SCR_WR   = 2'b10,
    PEND_SCR_RD   = 2'b11
  } pend_t;
endpackage
`default_nettype wire

// >>> scratch_store.sv
// scratch word storage with registered read data
// assumes write and read strobes are single-cycle and synchronous
`timescale 1ns/10ps
`default_nettype none
module scratch_store
#(
  parameter int WIDTH = 16
)
(
  input  wire logic             core_clk_in,  // controller clock
  input  wire logic             arst_n_in,    // async reset, active low
  input  wire logic             wr_en_in,     // store a word
  input  wire logic [WIDTH-1:0] wr_data_in,   // word to store
  input  wire logic             rd_en_in,     // capture read data
  output logic      [WIDTH-1:0] rd_data_out   // registered read data
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem_q;  // the scratch word

  // holds across suspend; only reset or a write changes it
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      mem_q <= WIDTH'(wlock_pkg::SCRATCH_RESET);
    else if (wr_en_in)
      mem_q <= wr_data_in;
  end

  // read port register; no bypass, so a read in the same cycle as a write gets the old word
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rd_data_out <= WIDTH'(wlock_pkg::WORD_ZERO);
    else if (rd_en_in)
      rd_data_out <= mem_q;
  end
endmodule // scratch_store
`default_nettype wire

// >>> wlock_scratch.sv
// write-lock and scratch register block of the device command port
// assumes suspend level from the suspend logic, strobes one cycle wide
`timescale 1ns/10ps
`default_nettype none
module wlock_scratch
#(
  parameter int WIDTH = wlock_pkg::WORD_W
)
(
  input  wire logic             core_clk_in,       // controller clock, 200 MHz
  input  wire logic             arst_n_in,         // async reset, active low
  input  wire logic             suspend_in,        // device suspended level
  input  wire logic             resume_in,         // one-cycle resume pulse
  input  wire logic             cmd_wr_in,         // command byte strobe
  input  wire logic [7:0]       cmd_in,            // command code
  input  wire logic             data_wr_in,        // data word write strobe
  input  wire logic [WIDTH-1:0] data_in,           // data word written
  input  wire logic             data_rd_in,        // data word read strobe
  output logic      [WIDTH-1:0] data_out,          // read word, next cycle
  output logic                  data_valid_out,    // read word valid pulse
  output logic                  wr_enable_out,     // writes allowed level
  output logic                  wr_block_out       // write was refused pulse
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  wlock_pkg::pend_t pend_q;      // data phase awaited
  logic             locked_q;    // write protection in force
  logic             scr_wr;      // scratch store write
  logic             scr_rd;      // scratch read capture
  logic [WIDTH-1:0] scr_rdata;   // scratch read word
  logic             key_hit;     // exact key in an unlock data phase
  logic             scr_wr_try;  // scratch write phase, allowed or not

  // writes are blocked when suspended or still locked
  wire logic wr_ok = !locked_q && !suspend_in;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // a data strobe serves the armed phase only when no command strobe
  // shares its cycle; the command wins and re-arms instead
  function automatic logic phase_strobe
  (
    input wlock_pkg::pend_t pend,    // phase armed now
    input wlock_pkg::pend_t want,    // phase this strobe serves
    input logic             strobe,  // data write or read strobe
    input logic             cmd      // command strobe in the same cycle
  );
    return (pend == want) && strobe && !cmd;
  endfunction

  // the key is compared as a whole word; a near miss such as one
  // flipped bit leaves the lock in force
  function automatic logic is_key
  (
    input logic [WIDTH-1:0] word     // data word from firmware
  );
    return word == WIDTH'(wlock_pkg::UNLOCK_KEY);
  endfunction

  // shared by the lock flop and the enable flop so both agree
  assign key_hit    = phase_strobe(pend_q, wlock_pkg::PEND_UNLOCK, data_wr_in, cmd_wr_in)
                      && is_key(data_in);
  assign scr_wr_try = phase_strobe(pend_q, wlock_pkg::PEND_SCR_WR, data_wr_in, cmd_wr_in);

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // a command arms exactly one data phase; unknown codes disarm
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      pend_q <= wlock_pkg::PEND_NONE;
    else if (cmd_wr_in)
    begin
      unique case (cmd_in)
        wlock_pkg::CMD_UNLOCK:     pend_q <= wlock_pkg::PEND_UNLOCK;
        wlock_pkg::CMD_SCRATCH_WR: pend_q <= wlock_pkg::PEND_SCR_WR;
        wlock_pkg::CMD_SCRATCH_RD: pend_q <= wlock_pkg::PEND_SCR_RD;
        default:                   pend_q <= wlock_pkg::PEND_NONE;
      endcase
    end
    else if (data_wr_in || data_rd_in)
      pend_q <= wlock_pkg::PEND_NONE;
  end

  // ----------------------------------------------------------------
  // lock state
  // ----------------------------------------------------------------
  // suspend sets the lock; only the exact key clears it, and only
  // once out of suspend, so a key during suspend is ignored
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      locked_q <= 1'b0;
    else if (suspend_in)
      locked_q <= 1'b1;
    else if (key_hit)
      locked_q <= 1'b0;
  end

  // scratch write only when writes are allowed
  assign scr_wr = scr_wr_try && wr_ok;
  // reads are never gated by the lock
  assign scr_rd = phase_strobe(pend_q, wlock_pkg::PEND_SCR_RD, data_rd_in, cmd_wr_in);

  scratch_store #(.WIDTH(WIDTH)) u_store
  (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .wr_en_in    (scr_wr),
    .wr_data_in  (data_in),
    .rd_en_in    (scr_rd),
    .rd_data_out (scr_rdata)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // read valid pulse follows the capture by one cycle
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      data_valid_out <= 1'b0;
    else
      data_valid_out <= scr_rd;
  end

  assign data_out = scr_rdata;

  // write-enable level for the rest of the controller
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      wr_enable_out <= 1'b1;
    else
      wr_enable_out <= !suspend_in && !(locked_q && !key_hit);
  end

  // refused scratch write is flagged for one cycle
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      wr_block_out <= 1'b0;
    else
      wr_block_out <= scr_wr_try && !wr_ok;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // the store may only change while writes are allowed
  a_no_write_locked: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    scr_wr |-> !locked_q && !suspend_in)
    else $error("scratch written while protected");

  // one sampled cycle of suspend is enough to lock
  a_suspend_locks: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    suspend_in |=> locked_q && !wr_enable_out)
    else $error("suspend did not lock");

  // a refused scratch write is flagged and keeps the enable low
  a_block_flags: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    scr_wr_try && (locked_q || suspend_in) |=> wr_block_out && !wr_enable_out)
    else $error("refused write not flagged");

  // reads answer one cycle later whatever the lock says
  a_read_answers: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    scr_rd |=> data_valid_out && data_out == $past(u_store.mem_q))
    else $error("scratch read failed");

  // read word stands until the next read capture
  a_read_data_holds: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    !scr_rd |=> $stable(data_out))
    else $error("read word changed without read");

  // the exact key clears the lock once out of suspend
  a_key_unlocks: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    pend_q == wlock_pkg::PEND_UNLOCK && data_wr_in && !cmd_wr_in && !suspend_in
    && data_in == WIDTH'(wlock_pkg::UNLOCK_KEY) |=> !locked_q)
    else $error("key did not unlock");

  // waking alone never unlocks; firmware must send the key
  a_resume_keeps_lock: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    resume_in && locked_q && !key_hit |=> locked_q)
    else $error("resume cleared the lock");

  // an open state with no suspend drives the enable high
  a_enable_follows: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    !locked_q && !suspend_in |=> wr_enable_out)
    else $error("writes not enabled when open");

  // a wrong word never opens the lock
  a_bad_key_stays: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    locked_q && data_wr_in && data_in != WIDTH'(wlock_pkg::UNLOCK_KEY) |=> locked_q)
    else $error("wrong key unlocked");

  // a data word closes the phase that its command opened
  a_one_data_word: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    data_wr_in && !cmd_wr_in |=> pend_q == wlock_pkg::PEND_NONE)
    else $error("data phase not closed");

  // a data strobe with no armed phase has no effect
  a_stray_data_ignored: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    pend_q == wlock_pkg::PEND_NONE && !cmd_wr_in |=> !data_valid_out && !wr_block_out)
    else $error("stray data strobe acted");

  // the scratch word survives everything but a write
  a_scratch_holds: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    !scr_wr |=> $stable(u_store.mem_q))
    else $error("scratch changed without write");

  // an allowed write lands in full
  a_scratch_stores: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    scr_wr |=> u_store.mem_q == $past(data_in))
    else $error("scratch write lost");
endmodule // wlock_scratch
`default_nettype wire

// >>> fw_host.sv
// firmware-side model: sends one command, then exactly one data word
// assumes the bench calls xfer between falling edges of the shared clock
`timescale 1ns/10ps
`default_nettype none
module fw_host
(
  input  wire logic        core_clk_in,  // controller clock
  input  wire logic [15:0] rd_word_in,   // word read back from device
  input  wire logic        valid_in,     // read word valid pulse
  input  wire logic        block_in,     // refused write pulse
  output logic             cmd_wr_out,   // command strobe
  output logic [7:0]       cmd_out,      // command code
  output logic             data_wr_out,  // data write strobe
  output logic [15:0]      data_out,     // data word to device
  output logic             data_rd_out   // data read strobe
);
  // ------------------------------------------------------------
  // one transfer; bus changes only at falling edges
  // ------------------------------------------------------------
  task automatic xfer(input logic [7:0] code, input logic [15:0] word,
                      output logic [15:0] rd, output logic vld, output logic blk);
    @(negedge core_clk_in);
    cmd_wr_out = 1'b1;
    cmd_out    = code;
    @(negedge core_clk_in);
    cmd_wr_out  = 1'b0;
    data_rd_out = (code == wlock_pkg::CMD_SCRATCH_RD);
    data_wr_out = !data_rd_out;
    // top bit of the scratch word is kept clear by firmware
    data_out = (code == wlock_pkg::CMD_SCRATCH_WR) ? {1'b0, word[14:0]} : word;
    @(negedge core_clk_in);
    rd  = rd_word_in;
    vld = valid_in;
    blk = block_in;
    data_wr_out = 1'b0;
    data_rd_out = 1'b0;
    data_out    = ~data_out;  // released bus does not keep the last word
  endtask
  initial
  begin
    cmd_wr_out  = 1'b0;
    cmd_out     = 8'h00;
    data_wr_out = 1'b0;
    data_rd_out = 1'b0;
    data_out    = 16'h_0000;
  end
endmodule  // fw_host
`default_nettype wire

// >>> wlock_scratch_tb.sv
// self-checking bench for the write-lock and scratch block
// assumes fw_host drives the command port; resume is pulsed once, as suspend drops
`timescale 1ns/10ps
`default_nettype none
module wlock_scratch_tb;
  logic        core_clk, arst_n, suspend, resume, cmd_wr, data_wr, data_rd;
  logic        valid, block, wr_en, v, b;
  logic [7:0]  cmd;
  logic [15:0] din, dout, rd;
  int          err_count, comparisons;
  always #2.5 core_clk = ~core_clk;  // 200 MHz
  wlock_scratch dut_u (.core_clk_in(core_clk), .arst_n_in(arst_n), .suspend_in(suspend),
    .resume_in(resume), .cmd_wr_in(cmd_wr), .cmd_in(cmd), .data_wr_in(data_wr),
    .data_in(din), .data_rd_in(data_rd), .data_out(dout), .data_valid_out(valid),
    .wr_enable_out(wr_en), .wr_block_out(block));
  fw_host fw_u (.core_clk_in(core_clk), .rd_word_in(dout), .valid_in(valid),
    .block_in(block), .cmd_wr_out(cmd_wr), .cmd_out(cmd), .data_wr_out(data_wr),
    .data_out(din), .data_rd_out(data_rd));
  // ------------------------------------------------------------
  // compare and verdict
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog: the sequence needs about 60 cycles, far below this
  initial
  begin
    #20000;
    err_count++;
    end_sim();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    suspend = 1'b0;
    resume = 1'b0;
    err_count = 0;
    comparisons = 0;
    repeat (8) @(negedge core_clk);
    arst_n = 1'b1;
    check(16'(wr_en), 16'h_0001);
    fw_u.xfer(wlock_pkg::CMD_SCRATCH_RD, 16'h_0000, rd, v, b);
    check(rd, wlock_pkg::SCRATCH_RESET);
    fw_u.xfer(wlock_pkg::CMD_SCRATCH_WR, 16'h_1234, rd, v, b);
    check(16'(b), 16'h_0000);
    fw_u.xfer(wlock_pkg::CMD_SCRATCH_RD, 16'h_0000, rd, v, b);
    check(rd, 16'h_1234);
    suspend = 1'b1;
    @(negedge core_clk);
    check(16'(wr_en), 16'h_0000);
    fw_u.xfer(wlock_pkg::CMD_SCRATCH_WR, 16'h_5555, rd, v, b);
    check(16'(b), 16'h_0001);
    fw_u.xfer(wlock_pkg::CMD_SCRATCH_RD, 16'h_0000, rd, v, b);
    check(16'(v), 16'h_0001);
    check(rd, 16'h_1234);
    fw_u.xfer(wlock_pkg::CMD_UNLOCK, wlock_pkg::UNLOCK_KEY, rd, v, b);
    check(16'(wr_en), 16'h_0000);
    suspend = 1'b0;
    resume = 1'b1;
    @(negedge core_clk);
    resume = 1'b0;
    @(negedge core_clk);
    check(16'(wr_en), 16'h_0000);
    fw_u.xfer(wlock_pkg::CMD_UNLOCK, 16'h_AA36, rd, v, b);
    check(16'(wr_en), 16'h_0000);
    fw_u.xfer(wlock_pkg::CMD_SCRATCH_WR, 16'h_0F0F, rd, v, b);
    check(16'(b), 16'h_0001);
    fw_u.xfer(wlock_pkg::CMD_SCRATCH_RD, 16'h_0000, rd, v, b);
    check(rd, 16'h_1234);
    fw_u.xfer(wlock_pkg::CMD_UNLOCK, wlock_pkg::UNLOCK_KEY, rd, v, b);
    check(16'(wr_en), 16'h_0001);
    fw_u.xfer(wlock_pkg::CMD_SCRATCH_WR, 16'h_FFFF, rd, v, b);
    check(16'(b), 16'h_0000);
    fw_u.xfer(wlock_pkg::CMD_SCRATCH_RD, 16'h_0000, rd, v, b);
    check(rd, 16'h_7FFF);
    // undecoded command: its data word must change nothing
    fw_u.xfer(8'h_B1, 16'h_0123, rd, v, b);
    check(16'(b), 16'h_0000);
    check(dout, 16'h_7FFF);
    fw_u.xfer(wlock_pkg::CMD_SCRATCH_RD, 16'h_0000, rd, v, b);
    check(rd, 16'h_7FFF);
    // second reset in mid-run: open again, scratch back to zero
    arst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    check(16'(wr_en), 16'h_0001);
    check(dout, wlock_pkg::WORD_ZERO);
    fw_u.xfer(wlock_pkg::CMD_SCRATCH_RD, 16'h_0000, rd, v, b);
    check(rd, wlock_pkg::SCRATCH_RESET);
    end_sim();
  end
endmodule  // wlock_scratch_tb
`default_nettype wire
